// >>> dv/ppm_board_model.sv
`timescale 1ns/1ps
module ppm_board_model (
    input  wire logic [6:0] int_d_i,
    input  wire logic [6:0] int_x_i,
    input  wire logic [7:0] pwm_d_i,
    input  wire logic [7:0] pwm_e_i,
    input  wire logic [7:0] ana_d_i,
    input  wire logic [7:0] dsp_d_i,
    input  wire logic [7:0] dsp_e_i,
    input  wire logic [7:0] pwm_x_i,
    input  wire logic [7:0] ana_x_i,
    input  wire logic [7:0] dsp_x_i,
    input  wire logic [1:0] sync_d_i,
    input  wire logic [1:0] sync_x_i,
    input  wire logic       rst_e_i,
    output logic      [6:0] int_p_o,
    output logic      [7:0] pwm_p_o,
    output logic      [7:0] ana_p_o,
    output logic      [7:0] dsp_p_o,
    output logic      [1:0] sync_p_o,
    output logic            rst_p_o
);
// test pin strapped low on this board, normal operation only
// pulled-up lines read low when either side pulls
assign int_p_o  = int_d_i & int_x_i;
assign ana_p_o  = ana_d_i & ana_x_i;
assign sync_p_o = sync_d_i & sync_x_i;
// three-state lines: device wins where enabled
assign pwm_p_o  = (pwm_d_i & pwm_e_i) | (pwm_x_i & ~pwm_e_i);
assign dsp_p_o  = (dsp_d_i & dsp_e_i) | (dsp_x_i & ~dsp_e_i);
assign rst_p_o  = ~rst_e_i;
endmodule

// >>> dv/ppm_port_mux_asserts.sv
`timescale 1ns/1ps
module ppm_port_mux_asserts (
    input wire logic        CLOCK_I,
    input wire logic        SRST_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic        PULSE_GEN_I,
    input wire logic        WDT_RESET_I,
    input wire logic        TRAP_RESET_I,
    input wire logic        CLK_RESET_I,
    input wire logic        RESET_PIN_OE_O,
    input wire logic        EXT_INT_THREE_O,
    input wire logic        REMOTE_CTRL_O,
    input wire logic [15:0] ADDR_I,
    input wire logic [7:0]  WDATA_I,
    input wire logic [7:0]  RDATA_O,
    input wire logic [7:0]  PWM_PORT_O,
    input wire logic [7:0]  PWM_PORT_OE_O,
    input wire logic [7:0]  PWM_GEN_I,
    input wire logic [7:0]  ANA_PORT_I,
    input wire logic [7:0]  ANA_PORT_O,
    input wire logic [7:0]  DSP_PORT_O,
    input wire logic [7:0]  DSP_PORT_OE_O,
    input wire logic [6:0]  INT_PORT_I,
    input wire logic [3:0]  DSP_COLOUR_I,
    input wire logic [3:0]  COMPARATOR_O,
    input wire logic [1:0]  ANA_PWM_GEN_I,
    input wire logic [1:0]  SYNC_PORT_I,
    input wire logic [1:0]  SYNC_IN_O
);
default clocking @(posedge CLOCK_I); endclocking
default disable iff (SRST_I);
property p_dir_reset; disable iff (1'b0)
    SRST_I ##1 SRST_I |-> PWM_PORT_OE_O == 8'h00 && DSP_PORT_OE_O == 8'h00; endproperty
property p_pwm_dir;
    WR_I && ADDR_I == ppm_pkg::ADDR_PWM_DIR |-> ##2 PWM_PORT_OE_O == $past(WDATA_I, 2); endproperty
property p_dsp_dir;
    WR_I && ADDR_I == ppm_pkg::ADDR_DSP_DIR |-> ##2 DSP_PORT_OE_O == $past(WDATA_I, 2); endproperty
property p_wide_pwm; WR_I && ADDR_I == ppm_pkg::ADDR_PWM_DATA && WDATA_I[0]
    |-> ##2 PWM_PORT_O[0] == $past(PWM_GEN_I[0]); endproperty
property p_colour; WR_I && ADDR_I == ppm_pkg::ADDR_DSP_FSEL && WDATA_I[7:4] == 4'hF
    |-> ##2 DSP_PORT_O[7:4] == $past(DSP_COLOUR_I); endproperty
property p_analog; !$past(SRST_I)
    |-> (ANA_PORT_O[2:0] & ~{$past(PULSE_GEN_I), $past(ANA_PWM_GEN_I)}) == 3'h0; endproperty
property p_cmp; !$past(SRST_I) |-> COMPARATOR_O == $past(ANA_PORT_I[7:4]); endproperty
property p_ext_interrupt_three; !$past(SRST_I) |-> EXT_INT_THREE_O == REMOTE_CTRL_O
    && (EXT_INT_THREE_O & ~$past(INT_PORT_I[0])) == 1'b0; endproperty
property p_sync; !$past(SRST_I) |-> (SYNC_IN_O & ~$past(SYNC_PORT_I)) == 2'h0; endproperty
property p_rst_pin; !RESET_PIN_OE_O && (WDT_RESET_I || TRAP_RESET_I || CLK_RESET_I)
    |-> ##1 RESET_PIN_OE_O [*8] ##1 !RESET_PIN_OE_O; endproperty
property p_rd_idle; !$past(RD_I) && !$past(SRST_I) |-> RDATA_O == 8'h00; endproperty
a_dir_reset: assert property (p_dir_reset) else $error("direction not input in reset");
a_pwm_dir: assert property (p_pwm_dir) else $error("pwm direction wrong");
a_dsp_dir: assert property (p_dsp_dir) else $error("display direction wrong");
a_wide_pwm: assert property (p_wide_pwm) else $error("wide pwm output wrong");
a_colour: assert property (p_colour) else $error("colour output wrong");
a_analog: assert property (p_analog) else $error("analog pwm or pulse wrong");
a_cmp: assert property (p_cmp) else $error("comparator input wrong");
a_ext_interrupt_three: assert property (p_ext_interrupt_three) else $error("interrupt three input wrong");
a_sync: assert property (p_sync) else $error("sync input wrong");
a_rst_pin: assert property (p_rst_pin) else $error("reset pin drive wrong");
a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
cover property (RESET_PIN_OE_O);
cover property (WR_I && ADDR_I == ppm_pkg::ADDR_DSP_FSEL);
cover property (EXT_INT_THREE_O);
endmodule

// >>> dv/ppm_port_mux_test.sv
`timescale 1ns/1ps
module ppm_port_mux_test;
logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, pulse = 1'b0;
logic wdt = 1'b0, trap = 1'b0, ckr = 1'b0;
logic [15:0] addr = 16'h0000;
logic [7:0] wdata = 8'h00, gen = 8'h00, x_pwm = 8'h3C, x_ana = 8'hFF, x_dsp = 8'hC3, q, n;
logic [6:0] x_int = 7'h7F;
logic [7:0] cause_exp [3] = '{8'h05, 8'h06, 8'h04};
logic [3:0] colour = 4'h0;
logic [1:0] agen = 2'h0, x_sync = 2'h3;
wire logic [7:0] rdata, pwm_o, pwm_oe, pwm_i, ana_o, ana_i, dsp_o, dsp_oe, dsp_i;
wire logic [6:0] int_o, int_i;
wire logic [3:0] cmp;
wire logic [1:0] sync_o, sync_i, sync_in;
wire logic rst_oe, rst_i, ext3, rc;
int n_mismatch = 0, comparisons = 0, cyc = 0;
typedef struct { logic [15:0] a; logic [7:0] d; logic [7:0] e; } ppm_row_s;
ppm_row_s rows [4] = '{'{ppm_pkg::ADDR_PWM_DIR, 8'hA5, 8'hA5}, '{16'h0F90, 8'h55, 8'h00},
    '{ppm_pkg::ADDR_DSP_DIR, 8'h5A, 8'h5A}, '{ppm_pkg::ADDR_DSP_FSEL, 8'hF0, 8'hF0}};
ppm_port_mux dut (.CLOCK_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .INT_PORT_I(int_i), .INT_PORT_O(int_o), .PWM_PORT_I(pwm_i),
    .PWM_PORT_O(pwm_o), .PWM_PORT_OE_O(pwm_oe), .ANA_PORT_I(ana_i), .ANA_PORT_O(ana_o),
    .DSP_PORT_I(dsp_i), .DSP_PORT_O(dsp_o), .DSP_PORT_OE_O(dsp_oe), .SYNC_PORT_I(sync_i),
    .SYNC_PORT_O(sync_o), .PWM_GEN_I(gen), .ANA_PWM_GEN_I(agen), .PULSE_GEN_I(pulse),
    .DSP_COLOUR_I(colour), .WDT_RESET_I(wdt), .TRAP_RESET_I(trap), .CLK_RESET_I(ckr),
    .RESET_PIN_I(rst_i), .RESET_PIN_OE_O(rst_oe), .EXT_INT_THREE_O(ext3),
    .REMOTE_CTRL_O(rc), .COMPARATOR_O(cmp), .SYNC_IN_O(sync_in));
ppm_board_model board (.int_d_i(int_o), .int_x_i(x_int), .pwm_d_i(pwm_o), .pwm_e_i(pwm_oe),
    .ana_d_i(ana_o), .dsp_d_i(dsp_o), .dsp_e_i(dsp_oe), .pwm_x_i(x_pwm), .ana_x_i(x_ana),
    .dsp_x_i(x_dsp), .sync_d_i(sync_o), .sync_x_i(x_sync), .rst_e_i(rst_oe), .int_p_o(int_i),
    .pwm_p_o(pwm_i), .ana_p_o(ana_i), .dsp_p_o(dsp_i), .sync_p_o(sync_i), .rst_p_o(rst_i));
always #50 clk = ~clk;
always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
        n_mismatch++;
        complete_run();
    end
end
task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
endtask
task automatic rd_reg(input logic [15:0] a, output logic [7:0] r);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 r = rdata;
endtask
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
        n_mismatch++;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
endtask
task automatic settle;
    repeat (3) @(posedge clk);
    #1;
endtask
task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    #1 chk(pwm_oe | dsp_oe, 8'h00);
    foreach (rows[i]) begin
        wr_reg(rows[i].a, rows[i].d);
        rd_reg(rows[i].a, q);
        chk(q, rows[i].e);
    end
    settle();
    chk(pwm_oe, 8'hA5);
    chk(dsp_oe, 8'h5A);
    wr_reg(ppm_pkg::ADDR_PWM_DIR, 8'hFF);
    @(posedge clk) gen <= 8'h81;
    wr_reg(ppm_pkg::ADDR_PWM_DATA, 8'hFF);
    settle();
    chk(pwm_o, 8'h81);
    wr_reg(ppm_pkg::ADDR_PWM_DATA, 8'hFE);
    settle();
    chk(pwm_o, 8'h80);
    @(posedge clk) colour <= 4'hA;
    settle();
    chk({4'h0, dsp_o[7:4]}, 8'h0A);
    wr_reg(ppm_pkg::ADDR_DSP_FSEL, 8'h00);
    wr_reg(ppm_pkg::ADDR_DSP_DATA, 8'h36);
    settle();
    chk(dsp_o, 8'h36);
    rd_reg(ppm_pkg::ADDR_DSP_DATA, q);
    chk(q, 8'h93);
    @(posedge clk) begin agen <= 2'b10; pulse <= 1'b1; x_ana <= 8'h9F; x_sync <= 2'b10; end
    settle();
    chk(ana_o, 8'hFE);
    chk({4'h0, cmp}, 8'h09);
    chk({6'h0, sync_in}, 8'h02);
    @(posedge clk) x_int <= 7'h01;
    settle();
    chk({6'h0, ext3, rc}, 8'h03);
    wr_reg(ppm_pkg::ADDR_INT_DATA, 8'h7E);
    settle();
    chk({6'h0, ext3, rc}, 8'h00);
    for (int k = 0; k < 3; k++) begin
        @(posedge clk) {ckr, trap, wdt} <= 3'b001 << k;
        @(posedge clk) {ckr, trap, wdt} <= 3'b000;
        n = 8'h00;
        repeat (12) begin
            #1 n += {7'h00, rst_oe};
            @(posedge clk);
        end
        chk(n, 8'h08);
        rd_reg(ppm_pkg::ADDR_RST_CTRL, q);
        chk(q, cause_exp[k]);
    end
    @(posedge clk) srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1 chk(pwm_oe | dsp_oe, 8'h00);
    complete_run();
end
endmodule
bind ppm_port_mux ppm_port_mux_asserts u_chk (
    .CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .WR_I(WR_I), .RD_I(RD_I),
    .PULSE_GEN_I(PULSE_GEN_I), .WDT_RESET_I(WDT_RESET_I), .TRAP_RESET_I(TRAP_RESET_I),
    .CLK_RESET_I(CLK_RESET_I), .RESET_PIN_OE_O(RESET_PIN_OE_O),
    .EXT_INT_THREE_O(EXT_INT_THREE_O), .REMOTE_CTRL_O(REMOTE_CTRL_O), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .PWM_PORT_O(PWM_PORT_O),
    .PWM_PORT_OE_O(PWM_PORT_OE_O), .PWM_GEN_I(PWM_GEN_I), .ANA_PORT_I(ANA_PORT_I),
    .ANA_PORT_O(ANA_PORT_O), .DSP_PORT_O(DSP_PORT_O), .DSP_PORT_OE_O(DSP_PORT_OE_O),
    .INT_PORT_I(INT_PORT_I), .DSP_COLOUR_I(DSP_COLOUR_I), .COMPARATOR_O(COMPARATOR_O),
    .ANA_PWM_GEN_I(ANA_PWM_GEN_I), .SYNC_PORT_I(SYNC_PORT_I), .SYNC_IN_O(SYNC_IN_O));

// >>> verilog/ppm_pkg.sv
package ppm_pkg;
    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_INT_DATA  = 16'h0F80;
    localparam logic [15:0] ADDR_PWM_DATA  = 16'h0F81;
    localparam logic [15:0] ADDR_PWM_DIR   = 16'h0F82;
    localparam logic [15:0] ADDR_ANA_DATA  = 16'h0F83;
    localparam logic [15:0] ADDR_DSP_DATA  = 16'h0F84;
    localparam logic [15:0] ADDR_DSP_DIR   = 16'h0F85;
    localparam logic [15:0] ADDR_SYNC_DATA = 16'h0F86;
    localparam logic [15:0] ADDR_RST_CTRL  = 16'h0F87;
    localparam logic [15:0] ADDR_DSP_FSEL  = 16'h0F91;
    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_LATCH8 = 8'hFF;
    localparam logic [6:0] RST_LATCH7 = 7'h7F;
    localparam logic [1:0] RST_LATCH2 = 2'h3;
    localparam logic [7:0] RST_DIR    = 8'h00;
    localparam logic [7:0] RST_FSEL   = 8'h00;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int ANA_PULSE_BIT = 2;
    localparam int SYNC_V_BIT    = 1;
    localparam int SYNC_H_BIT    = 0;
    localparam int EXT_INTERRUPT_THREE_BIT      = 0;
    // reset-pin drive length in cycles
    localparam logic [3:0] RST_OUT_CYCLES = 4'h8;

    typedef struct packed {
        logic [6:0]  int_latch;
        logic [7:0]  pwm_latch;
        logic [7:0]  pwm_dir;
        logic [7:0]  ana_latch;
        logic [7:0]  dsp_latch;
        logic [7:0]  dsp_dir;
        logic [1:0]  sync_latch;
        logic [7:0]  dsp_fsel;
        logic [7:0]  rdata;
        logic [3:0]  rst_cnt;
        logic [1:0]  rst_cause;
        logic [7:0]  pwm_o;
        logic [7:0]  pwm_oe;
        logic [7:0]  ana_o;
        logic [7:0]  dsp_o;
        logic [7:0]  dsp_oe;
        logic [1:0]  sync_o;
        logic [6:0]  int_o;
        logic        rst_pin_oe;
        logic        ext_interrupt_three_in;
        logic        rc_in;
        logic [3:0]  cmp_in;
        logic [1:0]  sync_in;
    } ppm_state_s;
endpackage

// >>> verilog/ppm_port_mux.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
// How it works
// RULE_01: each pwm port bit has its own direction bit, input or three-state output.
// RULE_02: under reset both direction registers clear, so every bit is an input.
// RULE_03: software sets a pwm port latch bit to one before using it as pwm output.
// RULE_04: pwm port bit 0 carries the wide pwm output, bits 1 to 7 the narrow ones.
// RULE_05: analog port latch bits stay one for inputs, comparator, pwm and pulse use.
// RULE_06: analog bits 7..4 feed comparators, bit 2 gives pulse, bits 1..0 pwm.
// RULE_07: each display port bit has its own direction; upper half tri-state, lower strong. The code drives all eight bits alike.
// RULE_08: software sets select bits 7 to 4 to route display colour and blanking out.
// RULE_09: display bit 7 gives focus/blank, bits 6, 5, 4 give blue, green, red.
// RULE_10: sync port bit 1 takes vertical and bit 0 horizontal sync, latches at one.
// RULE_11: interrupt port bit 0 is external interrupt three or the remote input.
// RULE_12: an external clock enters the oscillator input pin, output pin left open.
// RULE_13: the reset pin is an input and is driven on watchdog, trap and clock reset.
// RULE_14: the board holds the test pin low in normal operation.
// RULE_15: interrupt port latch bits stay one for inputs, timer, remote and interrupt use.
// RULE_16: a latch bit of zero pulls the pin low, one releases it to the outside level.
module ppm_port_mux (
    // ------------------------------------------------------------------
    // clock, reset and register bus
    // ------------------------------------------------------------------
    input  wire logic        CLOCK_I,
    input  wire logic        SRST_I,
    input  wire logic [15:0] ADDR_I,
    input  wire logic [7:0]  WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [7:0]  RDATA_O,
    // ------------------------------------------------------------------
    // port pins
    // ------------------------------------------------------------------
    input  wire logic [6:0]  INT_PORT_I,
    output logic      [6:0]  INT_PORT_O,
    input  wire logic [7:0]  PWM_PORT_I,
    output logic      [7:0]  PWM_PORT_O,
    output logic      [7:0]  PWM_PORT_OE_O,
    input  wire logic [7:0]  ANA_PORT_I,
    output logic      [7:0]  ANA_PORT_O,
    input  wire logic [7:0]  DSP_PORT_I,
    output logic      [7:0]  DSP_PORT_O,
    output logic      [7:0]  DSP_PORT_OE_O,
    input  wire logic [1:0]  SYNC_PORT_I,
    output logic      [1:0]  SYNC_PORT_O,
    // ------------------------------------------------------------------
    // peripheral outputs routed to pins
    // ------------------------------------------------------------------
    input  wire logic [7:0]  PWM_GEN_I,
    input  wire logic [1:0]  ANA_PWM_GEN_I,
    input  wire logic        PULSE_GEN_I,
    input  wire logic [3:0]  DSP_COLOUR_I,
    // ------------------------------------------------------------------
    // reset sources and reset pin
    // ------------------------------------------------------------------
    input  wire logic        WDT_RESET_I,
    input  wire logic        TRAP_RESET_I,
    input  wire logic        CLK_RESET_I,
    input  wire logic        RESET_PIN_I,
    output logic             RESET_PIN_OE_O,
    // ------------------------------------------------------------------
    // pin inputs routed to peripherals
    // ------------------------------------------------------------------
    output logic             EXT_INT_THREE_O,
    output logic             REMOTE_CTRL_O,
    output logic      [3:0]  COMPARATOR_O,
    output logic      [1:0]  SYNC_IN_O
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    ppm_pkg::ppm_state_s s_reg;
    ppm_pkg::ppm_state_s s_next;
    logic [7:0] pwm_pin;
    logic [7:0] dsp_pin;
    logic [7:0] dsp_src;

    // ------------------------------------------------------------------
    // pin level seen by software
    // ------------------------------------------------------------------
    function automatic logic [7:0] pin_level(input logic [7:0] oe,
                                             input logic [7:0] drv,
                                             input logic [7:0] ext);
        pin_level = (oe & drv) | (~oe & ext);
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        // ------------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------------
        if (WR_I) begin
            unique case (ADDR_I)
                ppm_pkg::ADDR_INT_DATA:  s_next.int_latch  = WDATA_I[6:0];
                ppm_pkg::ADDR_PWM_DATA:  s_next.pwm_latch  = WDATA_I;
                ppm_pkg::ADDR_PWM_DIR:   s_next.pwm_dir    = WDATA_I; // RULE_01
                ppm_pkg::ADDR_ANA_DATA:  s_next.ana_latch  = WDATA_I;
                ppm_pkg::ADDR_DSP_DATA:  s_next.dsp_latch  = WDATA_I;
                ppm_pkg::ADDR_DSP_DIR:   s_next.dsp_dir    = WDATA_I; // RULE_07
                ppm_pkg::ADDR_SYNC_DATA: s_next.sync_latch = WDATA_I[1:0];
                ppm_pkg::ADDR_DSP_FSEL:  s_next.dsp_fsel   = WDATA_I;
                default: ;
            endcase
        end
        // ------------------------------------------------------------------
        // register reads, pins return outside level
        // ------------------------------------------------------------------
        s_next.rdata = 8'h00;
        if (RD_I) begin
            unique case (ADDR_I)
                ppm_pkg::ADDR_INT_DATA:  s_next.rdata = {1'b0, INT_PORT_I & s_reg.int_latch};
                ppm_pkg::ADDR_PWM_DATA:  s_next.rdata = pwm_pin;
                ppm_pkg::ADDR_PWM_DIR:   s_next.rdata = s_reg.pwm_dir;
                ppm_pkg::ADDR_ANA_DATA:  s_next.rdata = ANA_PORT_I & s_reg.ana_o; // RULE_16
                ppm_pkg::ADDR_DSP_DATA:  s_next.rdata = dsp_pin;
                ppm_pkg::ADDR_DSP_DIR:   s_next.rdata = s_reg.dsp_dir;
                ppm_pkg::ADDR_SYNC_DATA: s_next.rdata = {6'h00, SYNC_PORT_I & s_reg.sync_latch};
                ppm_pkg::ADDR_RST_CTRL:  s_next.rdata = {5'h00, RESET_PIN_I, s_reg.rst_cause};
                ppm_pkg::ADDR_DSP_FSEL:  s_next.rdata = s_reg.dsp_fsel;
                default:                 s_next.rdata = 8'h00;
            endcase
        end
        // ------------------------------------------------------------------
        // pin drive
        // ------------------------------------------------------------------
        s_next.pwm_oe = s_reg.pwm_dir; // RULE_01
        s_next.pwm_o  = s_reg.pwm_latch & PWM_GEN_I; // RULE_04
        s_next.ana_o  = s_reg.ana_latch; // RULE_16
        s_next.ana_o[1:0] = s_reg.ana_latch[1:0] & ANA_PWM_GEN_I; // RULE_06
        s_next.ana_o[ppm_pkg::ANA_PULSE_BIT] =
            s_reg.ana_latch[ppm_pkg::ANA_PULSE_BIT] & PULSE_GEN_I; // RULE_06
        s_next.dsp_oe = s_reg.dsp_dir; // RULE_07
        s_next.dsp_o  = dsp_src; // RULE_09
        s_next.sync_o = s_reg.sync_latch; // RULE_16
        s_next.int_o  = s_reg.int_latch; // RULE_16
        // ------------------------------------------------------------------
        // input routing to peripherals
        // ------------------------------------------------------------------
        s_next.ext_interrupt_three_in = INT_PORT_I[ppm_pkg::EXT_INTERRUPT_THREE_BIT]
                         & s_reg.int_latch[ppm_pkg::EXT_INTERRUPT_THREE_BIT]; // RULE_11
        s_next.rc_in   = s_next.ext_interrupt_three_in; // RULE_11
        s_next.cmp_in  = ANA_PORT_I[7:4]; // RULE_06
        s_next.sync_in = {SYNC_PORT_I[ppm_pkg::SYNC_V_BIT] & s_reg.sync_latch[1],
                          SYNC_PORT_I[ppm_pkg::SYNC_H_BIT] & s_reg.sync_latch[0]}; // RULE_10
        // ------------------------------------------------------------------
        // reset pin output
        // ------------------------------------------------------------------
        if (WDT_RESET_I || TRAP_RESET_I || CLK_RESET_I) begin
            s_next.rst_cnt   = ppm_pkg::RST_OUT_CYCLES; // RULE_13
            s_next.rst_cause = {TRAP_RESET_I, WDT_RESET_I};
        end else if (s_reg.rst_cnt != 4'h0) begin
            s_next.rst_cnt = s_reg.rst_cnt - 4'h1;
        end
        s_next.rst_pin_oe = (s_next.rst_cnt != 4'h0); // RULE_13
        // ------------------------------------------------------------------
        // reset
        // ------------------------------------------------------------------
        if (SRST_I) begin
            s_next = '0;
            s_next.int_latch  = ppm_pkg::RST_LATCH7;
            s_next.pwm_latch  = ppm_pkg::RST_LATCH8;
            s_next.pwm_dir    = ppm_pkg::RST_DIR; // RULE_02
            s_next.ana_latch  = ppm_pkg::RST_LATCH8;
            s_next.dsp_latch  = ppm_pkg::RST_LATCH8;
            s_next.dsp_dir    = ppm_pkg::RST_DIR; // RULE_02
            s_next.sync_latch = ppm_pkg::RST_LATCH2;
            s_next.dsp_fsel   = ppm_pkg::RST_FSEL;
            s_next.pwm_o      = ppm_pkg::RST_LATCH8;
            s_next.ana_o      = ppm_pkg::RST_LATCH8;
            s_next.dsp_o      = ppm_pkg::RST_LATCH8;
            s_next.sync_o     = ppm_pkg::RST_LATCH2;
            s_next.int_o      = ppm_pkg::RST_LATCH7;
            s_next.rst_cause  = s_reg.rst_cause;
        end
    end

    // ------------------------------------------------------------------
    // display source select
    // ------------------------------------------------------------------
    for (genvar g = 0; g < 8; g++) begin : g_dsp_src
        if (g >= 4) begin : g_osd
            assign dsp_src[g] = s_reg.dsp_fsel[g] ? DSP_COLOUR_I[g - 4]
                                                  : s_reg.dsp_latch[g]; // RULE_08
        end else begin : g_port
            assign dsp_src[g] = s_reg.dsp_latch[g];
        end
    end

    // ------------------------------------------------------------------
    // pin levels for data reads
    // ------------------------------------------------------------------
    assign pwm_pin = pin_level(s_reg.pwm_oe, s_reg.pwm_o, PWM_PORT_I);
    assign dsp_pin = pin_level(s_reg.dsp_oe, s_reg.dsp_o, DSP_PORT_I);

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        s_reg <= s_next;
    end

    // ------------------------------------------------------------------
    // outputs straight from flip-flops
    // ------------------------------------------------------------------
    assign RDATA_O         = s_reg.rdata;
    assign INT_PORT_O      = s_reg.int_o;
    assign PWM_PORT_O      = s_reg.pwm_o;
    assign PWM_PORT_OE_O   = s_reg.pwm_oe;
    assign ANA_PORT_O      = s_reg.ana_o;
    assign DSP_PORT_O      = s_reg.dsp_o;
    assign DSP_PORT_OE_O   = s_reg.dsp_oe;
    assign SYNC_PORT_O     = s_reg.sync_o;
    assign RESET_PIN_OE_O  = s_reg.rst_pin_oe;
    assign EXT_INT_THREE_O = s_reg.ext_interrupt_three_in;
    assign REMOTE_CTRL_O   = s_reg.rc_in;
    assign COMPARATOR_O    = s_reg.cmp_in;
    assign SYNC_IN_O       = s_reg.sync_in;
endmodule
